// ===== hdl/dpsd_params.svh
/*
  Register offsets, control field positions, reset values and counts
  for the dual pulse-width / sigma-delta modulator.
  Assumes inclusion by bare name from the modulator design files.
*/
`ifndef DPSD_PARAMS_SVH
`define DPSD_PARAMS_SVH

// Register offsets on the plain register port
`define DPSD_OFS_CTRL   3'h0
`define DPSD_OFS_CH0L   3'h1
`define DPSD_OFS_CH0H   3'h2
`define DPSD_OFS_CH1L   3'h3
`define DPSD_OFS_CH1H   3'h4
`define DPSD_OFS_CNTL   3'h5
`define DPSD_OFS_CNTH   3'h6

// Control register fields
`define DPSD_F_SINGLE_OUTPUT_ONLY     7
`define DPSD_F_MODE_HI  6
`define DPSD_F_MODE_LO  4
`define DPSD_F_DIV_HI   3
`define DPSD_F_DIV_LO   2
`define DPSD_F_SRC_HI   1
`define DPSD_F_SRC_LO   0

// Reset values
`define DPSD_CTRL_RST   8'h00
`define DPSD_DATA_RST   16'h0000

// Counts
`define DPSD_XTAL_LAST  4'he
`define DPSD_FULL16     17'h10000
`define DPSD_FULL8      17'h00100
`define DPSD_DIV1_LAST  6'h00
`define DPSD_DIV4_LAST  6'h03
`define DPSD_DIV16_LAST 6'h0f
`define DPSD_DIV64_LAST 6'h3f

`endif

// ===== hdl/dpsd_pkg.sv
/*
  Types for the dual pulse-width / sigma-delta modulator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpsd_pkg;

  typedef enum logic [2:0] {
    DPSD_M_OFF   = 3'h0,
    DPSD_M_VAR   = 3'h1,
    DPSD_M_TWIN8 = 3'h2,
    DPSD_M_TW16  = 3'h3,
    DPSD_M_NRZ   = 3'h4,
    DPSD_M_DUAL8 = 3'h5,
    DPSD_M_RZ    = 3'h6,
    DPSD_M_RSVD  = 3'h7
  } dpsd_mode_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  hid0;
    logic [7:0]  hid1;
    logic [15:0] reg0;
    logic [15:0] reg1;
    logic [15:0] act0;
    logic [15:0] act1;
    logic [15:0] cnt;
    logic [7:0]  cntb;
    logic [15:0] acc0;
    logic [15:0] acc1;
    logic        o0;
    logic        o1;
    logic [7:0]  rdata;
  } dpsd_state_t;

  typedef struct packed {
    logic [3:0] xdiv;
    logic       ext_q;
    logic [5:0] pre;
  } dpsd_pre_state_t;

endpackage : dpsd_pkg

// ===== hdl/dpsd_prescale.sv
/*
  Clock source selection and prescaler for the modulator counter.
  Assumes the crystal tick and external clock inputs are synchronous
  to clk_i; produces a one-cycle modulator tick and a first-half flag.
*/
`timescale 1ns/1ns
`include "dpsd_params.svh"

module dpsd_prescale
  import dpsd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] src_sel_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       xtal_tick_i,
  input  wire logic       ext_clk_i,
  output logic            tick_o,
  output logic            half_o
);

  dpsd_pre_state_t s_q;
  dpsd_pre_state_t s_d;
  logic            src_tick;
  logic [5:0]      lim;

  function automatic logic [5:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h0:    div_last = `DPSD_DIV1_LAST;
      2'h1:    div_last = `DPSD_DIV4_LAST;
      2'h2:    div_last = `DPSD_DIV16_LAST;
      default: div_last = `DPSD_DIV64_LAST;
    endcase
  endfunction : div_last

  always_comb
  begin
    lim = div_last(div_sel_i);
    case (src_sel_i)
      2'h0:    src_tick = (s_q.xdiv == `DPSD_XTAL_LAST);
      2'h1:    src_tick = xtal_tick_i;
      2'h2:    src_tick = ext_clk_i & ~s_q.ext_q;
      default: src_tick = 1'b1;
    endcase
    tick_o = ce_i & src_tick & (s_q.pre == lim) & ~restart_i;
    // Divide by one cannot be halved; whole cycle counts as first half
    half_o = (lim == `DPSD_DIV1_LAST) ||
             ({1'b0, s_q.pre} < (({1'b0, lim} + 7'h01) >> 1));
  end

  always_comb
  begin
    s_d = s_q;
    if (ce_i)
    begin
      s_d.ext_q = ext_clk_i;
      s_d.xdiv = (s_q.xdiv == `DPSD_XTAL_LAST) ? 4'h0 : s_q.xdiv + 4'h1;
      if (restart_i)
      begin
        s_d.pre  = 6'h00;
        s_d.xdiv = 4'h0;
      end
      else if (src_tick)
      begin
        s_d.pre = (s_q.pre >= lim) ? 6'h00 : s_q.pre + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule : dpsd_prescale

// ===== hdl/dpsd_top.sv
/*
  Dual-output pulse-width modulator and sigma-delta density generator
  with control, data registers and a shared counter.
  Assumes a synchronous register port with read data one cycle later;
  the output enables steer two port pins outside this block.
*/
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "dpsd_params.svh"

module dpsd_top
  import dpsd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  input  wire logic       xtal_tick_i,
  input  wire logic       ext_clk_i,
  output logic            out0_o,
  output logic            out0_oe_o,
  output logic            out1_o,
  output logic            out1_oe_o
);

  dpsd_state_t s_q;
  dpsd_state_t s_d;
  dpsd_mode_t  mode;
  dpsd_mode_t  nmode;
  logic        tick;
  logic        half;
  logic        ctrl_wr;
  logic        wrap;
  logic        wrapb;
  logic [16:0] inc;
  logic [16:0] per0;
  logic [8:0]  incb;
  logic [8:0]  perb;
  logic [15:0] cnt_nx;
  logic [7:0]  cntb_nx;
  logic [15:0] act0_nx;
  logic [15:0] act1_nx;
  logic [16:0] sum0;
  logic [16:0] sum1;

  // Modes whose data registers take the hidden low-byte path
  function automatic logic is16(input dpsd_mode_t m);
    is16 = (m == DPSD_M_VAR) || (m == DPSD_M_TW16) ||
           (m == DPSD_M_NRZ) || (m == DPSD_M_RZ);
  endfunction : is16

  // Zero period in a programmed mode counts as the full range
  function automatic logic [16:0] period_of(input dpsd_mode_t m,
                                            input logic [15:0] v);
    case (m)
      DPSD_M_VAR:
        period_of = (v == 16'h0000) ? `DPSD_FULL16 : {1'b0, v};
      DPSD_M_TWIN8, DPSD_M_DUAL8:
        period_of = (v[7:0] == 8'h00) ? `DPSD_FULL8 : {9'h000, v[7:0]};
      default:
        period_of = `DPSD_FULL16;
    endcase
  endfunction : period_of

  function automatic logic runs(input dpsd_mode_t m);
    runs = (m != DPSD_M_OFF) && (m != DPSD_M_RSVD);
  endfunction : runs

  dpsd_prescale u_prescale (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .restart_i   (ctrl_wr),
    .src_sel_i   (s_q.ctrl[`DPSD_F_SRC_HI:`DPSD_F_SRC_LO]),
    .div_sel_i   (s_q.ctrl[`DPSD_F_DIV_HI:`DPSD_F_DIV_LO]),
    .xtal_tick_i (xtal_tick_i),
    .ext_clk_i   (ext_clk_i),
    .tick_o      (tick),
    .half_o      (half)
  );

  always_comb
  begin
    mode    = dpsd_mode_t'(s_q.ctrl[`DPSD_F_MODE_HI:`DPSD_F_MODE_LO]);
    nmode   = dpsd_mode_t'(wdata_i[`DPSD_F_MODE_HI:`DPSD_F_MODE_LO]);
    ctrl_wr = ce_i & we_i & (addr_i == `DPSD_OFS_CTRL);
    per0    = period_of(mode, s_q.act1);
    inc     = {1'b0, s_q.cnt} + 17'h00001;
    wrap    = (inc == per0);
    cnt_nx  = wrap ? 16'h0000 : inc[15:0];
    perb    = (s_q.act1[15:8] == 8'h00) ? 9'h100 : {1'b0, s_q.act1[15:8]};
    incb    = {1'b0, s_q.cntb} + 9'h001;
    wrapb   = (incb == perb);
    cntb_nx = wrapb ? 8'h00 : incb[7:0];
    // New values take effect only at the start of a period
    act0_nx = s_q.act0;
    act1_nx = s_q.act1;
    if (wrap)
    begin
      act0_nx[7:0] = s_q.reg0[7:0];
      act1_nx[7:0] = s_q.reg1[7:0];
    end
    if ((mode == DPSD_M_DUAL8) ? wrapb : wrap)
    begin
      act0_nx[15:8] = s_q.reg0[15:8];
      act1_nx[15:8] = s_q.reg1[15:8];
    end
    sum0 = {1'b0, s_q.acc0} + {1'b0, s_q.act0};
    sum1 = {1'b0, s_q.acc1} + {1'b0, s_q.act1};
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    if (ce_i)
    begin
      if (we_i)
      begin
        case (addr_i)
          `DPSD_OFS_CTRL: s_d.ctrl = wdata_i;
          `DPSD_OFS_CH0L:
            if (is16(mode))
              s_d.hid0 = wdata_i;
            else
              s_d.reg0[7:0] = wdata_i;
          `DPSD_OFS_CH0H:
            if (is16(mode))
              s_d.reg0 = {wdata_i, s_q.hid0};
            else
              s_d.reg0[15:8] = wdata_i;
          `DPSD_OFS_CH1L:
            if (is16(mode))
              s_d.hid1 = wdata_i;
            else
              s_d.reg1[7:0] = wdata_i;
          `DPSD_OFS_CH1H:
            if (is16(mode))
              s_d.reg1 = {wdata_i, s_q.hid1};
            else
              s_d.reg1[15:8] = wdata_i;
          default: s_d.rdata = 8'h00;
        endcase
      end
      if (re_i)
      begin
        case (addr_i)
          `DPSD_OFS_CTRL: s_d.rdata = s_q.ctrl;
          `DPSD_OFS_CH0L: s_d.rdata = s_q.reg0[7:0];
          `DPSD_OFS_CH0H: s_d.rdata = s_q.reg0[15:8];
          `DPSD_OFS_CH1L: s_d.rdata = s_q.reg1[7:0];
          `DPSD_OFS_CH1H: s_d.rdata = s_q.reg1[15:8];
          `DPSD_OFS_CNTL: s_d.rdata = s_q.cnt[7:0];
          `DPSD_OFS_CNTH: s_d.rdata = s_q.cnt[15:8];
          default:        s_d.rdata = 8'h00;
        endcase
      end
      if (ctrl_wr)
      begin
        // Restart from a clean period with the committed values
        s_d.cnt  = 16'h0000;
        s_d.cntb = 8'h00;
        s_d.acc0 = 16'h0000;
        s_d.acc1 = 16'h0000;
        s_d.act0 = s_q.reg0;
        s_d.act1 = s_q.reg1;
        // Outputs restart at their count-zero level, not low
        s_d.o0   = ((nmode == DPSD_M_TW16) && (s_q.reg0 != 16'h0000)) ||
                   (((nmode == DPSD_M_TWIN8) || (nmode == DPSD_M_DUAL8)) &&
                    (s_q.reg0[7:0] != 8'h00));
        s_d.o1   = ((nmode == DPSD_M_VAR) && (s_q.reg0 != 16'h0000)) ||
                   ((nmode == DPSD_M_TW16) && (s_q.reg1 != 16'h0000)) ||
                   ((nmode == DPSD_M_DUAL8) && (s_q.reg0[15:8] != 8'h00)) ||
                   ((nmode == DPSD_M_TWIN8) && (s_q.reg1[15:8] == 8'h00) &&
                    (s_q.reg0[15:8] != 8'h00));
      end
      else if (!runs(mode))
      begin
        s_d.cnt  = 16'h0000;
        s_d.cntb = 8'h00;
        s_d.o0   = 1'b0;
        s_d.o1   = 1'b0;
      end
      else if (tick)
      begin
        s_d.cnt  = cnt_nx;
        s_d.cntb = cntb_nx;
        s_d.act0 = act0_nx;
        s_d.act1 = act1_nx;
        case (mode)
          DPSD_M_VAR:
          begin
            s_d.o0 = 1'b0;
            s_d.o1 = (cnt_nx < act0_nx);
          end
          DPSD_M_TWIN8:
          begin
            s_d.o0 = (cnt_nx[7:0] < act0_nx[7:0]);
            // Fall has priority when both compare values coincide
            if (cnt_nx[7:0] == act0_nx[15:8])
              s_d.o1 = 1'b0;
            else if (cnt_nx[7:0] == act1_nx[15:8])
              s_d.o1 = 1'b1;
          end
          DPSD_M_TW16:
          begin
            s_d.o0 = (cnt_nx < act0_nx);
            s_d.o1 = (cnt_nx < act1_nx);
          end
          DPSD_M_DUAL8:
          begin
            s_d.o0 = (cnt_nx[7:0] < act0_nx[7:0]);
            s_d.o1 = (cntb_nx < act0_nx[15:8]);
          end
          DPSD_M_NRZ, DPSD_M_RZ:
          begin
            // First-order accumulator carries give exact density
            s_d.acc0 = sum0[15:0];
            s_d.acc1 = sum1[15:0];
            s_d.o0   = sum0[16];
            s_d.o1   = sum1[16];
          end
          default:
          begin
            s_d.o0 = 1'b0;
            s_d.o1 = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_comb
  begin
    rdata_o   = s_q.rdata;
    out0_oe_o = runs(mode) && (mode != DPSD_M_VAR) &&
                !s_q.ctrl[`DPSD_F_SINGLE_OUTPUT_ONLY];
    out1_oe_o = runs(mode);
    // RZ returns low in the second half of every modulator tick, except with the divide-by-one prescaler
    out0_o = s_q.o0 & ((mode != DPSD_M_RZ) | half);
    out1_o = s_q.o1 & ((mode != DPSD_M_RZ) | half);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    ce_i && we_i && (addr_i == `DPSD_OFS_CTRL);
  endsequence

  sequence s_high_commit0;
    ce_i && we_i && (addr_i == `DPSD_OFS_CH0H) && is16(mode);
  endsequence

  a_off_no_drive: assert property (
    !runs(mode) |-> !out0_oe_o && !out1_oe_o && s_q.cnt == 16'h0000)
    else $error("disabled mode drives a pin");

  a_ctrl_wr_clear: assert property (
    s_ctrl_write |=> s_q.cnt == 16'h0000 && s_q.cntb == 8'h00)
    else $error("control write left counter running");

  a_var_period_wrap: assert property (
    (mode == DPSD_M_VAR) && ce_i && tick && !we_i &&
    ({1'b0, s_q.cnt} + 17'h00001 == period_of(mode, s_q.act1))
    |=> s_q.cnt == 16'h0000)
    else $error("single mode period not honoured");

  a_tw16_sync_rise: assert property (
    (mode == DPSD_M_TW16) && ce_i && tick && !we_i &&
    s_q.cnt == 16'hffff && s_q.reg0 != 16'h0000 &&
    s_q.reg1 != 16'h0000
    |=> s_q.o0 && s_q.o1 && s_q.cnt == 16'h0000)
    else $error("twin 16-bit outputs not rising together");

  a_tw16_duty_fall: assert property (
    (mode == DPSD_M_TW16) && ce_i && tick && !we_i &&
    (s_q.cnt + 16'h0001 == s_q.act0) && s_q.cnt != 16'hffff
    |=> !s_q.o0)
    else $error("twin 16-bit output 0 missed its fall");

  a_nrz_zero_low: assert property (
    (mode == DPSD_M_NRZ) && ce_i && tick && s_q.act0 == 16'h0000 &&
    s_q.acc0 == 16'h0000 && !we_i
    |=> !s_q.o0)
    else $error("zero density produced a high");

  a_nrz_full_rate: assert property (
    (mode == DPSD_M_NRZ) && ce_i && tick && !we_i &&
    ({1'b0, s_q.acc1} + {1'b0, s_q.act1} >= `DPSD_FULL16)
    |=> s_q.o1)
    else $error("density carry not shown on output 1");

  a_rz_half_only: assert property (
    (mode == DPSD_M_RZ) && tick &&
    (s_q.ctrl[`DPSD_F_DIV_HI:`DPSD_F_DIV_LO] != 2'h0)
    |-> !out0_o && !out1_o)
    else $error("return-to-zero high in second half of tick");

  a_low_byte_hidden: assert property (
    ce_i && we_i && (addr_i == `DPSD_OFS_CH0L) && is16(mode)
    |=> s_q.reg0 == $past(s_q.reg0))
    else $error("low byte reached the visible register");

  a_high_commit: assert property (
    s_high_commit0 |=> s_q.reg0 == {$past(wdata_i), $past(s_q.hid0)})
    else $error("high byte write did not commit both bytes");

  a_twin8_out1_set: assert property (
    (mode == DPSD_M_TWIN8) && ce_i && tick && !we_i &&
    (cnt_nx[7:0] == act1_nx[15:8]) && (act1_nx[15:8] != act0_nx[15:8])
    |=> s_q.o1)
    else $error("twin 8-bit output 1 did not rise");

  a_read_answer: assert property (
    ce_i && re_i && !we_i && (addr_i == `DPSD_OFS_CTRL)
    |=> rdata_o == $past(s_q.ctrl) ##1
        (rdata_o == 8'h00 || $past(re_i) || !$past(ce_i)))
    else $error("read data not one cycle later");

endmodule : dpsd_top

// ===== dv/dpsd_pin_load.sv
/*
  Load on the two modulator port pins: resolves each pin level and
  counts driven-high clocks per window, plus longest high run of pin 0.
  Assumes an undriven pin is held high by a weak pull-up.
*/
`timescale 1ns/1ns

module dpsd_pin_load (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic [1:0] lvl_i,
  input  wire logic [1:0] oe_i,
  output logic      [1:0] pin_o,
  output int              high0_o,
  output int              high1_o,
  output int              run0_o
);
  int run;

  // Undriven pin floats up to the pull-up, never shows the last level
  assign pin_o = (lvl_i & oe_i) | ~oe_i;

  always @(posedge clk_i)
  begin
    if (clr_i)
    begin
      high0_o <= 0;
      high1_o <= 0;
      run0_o  <= 0;
      run     <= 0;
    end
    else
    begin
      high0_o <= high0_o + int'(lvl_i[0] & oe_i[0]);
      high1_o <= high1_o + int'(lvl_i[1] & oe_i[1]);
      run     <= (lvl_i[0] & oe_i[0]) ? run + 1 : 0;
      if ((lvl_i[0] & oe_i[0]) && run + 1 > run0_o)
        run0_o <= run + 1;
    end
  end
endmodule : dpsd_pin_load

// ===== dv/dpsd_top_test.sv
/*
  Self-checking bench for the dual modulator: register port, modes,
  clock sources, prescaler, hidden-byte commit and counter restart.
  Assumes the pin load model counts driven-high clocks per window.
*/
`timescale 1ns/1ns
`include "dpsd_params.svh"

module dpsd_top_test
  import dpsd_pkg::*;
;
  logic       clk_i, rst_i, ce_i, we_i, re_i, xtal_tick_i, ext_clk_i, clr;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic       out0_o, out0_oe_o, out1_o, out1_oe_o;
  logic [1:0] pin;
  int         high0, high1, run0, mismatches, cmp_count;
  int         tck = 0;

  dpsd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .xtal_tick_i(xtal_tick_i), .ext_clk_i(ext_clk_i),
    .out0_o(out0_o), .out0_oe_o(out0_oe_o), .out1_o(out1_o),
    .out1_oe_o(out1_oe_o));

  dpsd_pin_load u_load (.clk_i(clk_i), .clr_i(clr),
    .lvl_i({out1_o, out0_o}), .oe_i({out1_oe_o, out0_oe_o}),
    .pin_o(pin), .high0_o(high0), .high1_o(high1), .run0_o(run0));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Crystal tick every 3 clocks, external clock rising every 8
  always @(posedge clk_i)
  begin
    tck         <= tck + 1;
    xtal_tick_i <= (tck % 3 == 2);
    ext_clk_i   <= ((tck / 4) % 2 == 1);
  end

  task automatic check(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic setup(input logic [15:0] c0, c1);
    wr(`DPSD_OFS_CTRL, 8'h00);
    wr(`DPSD_OFS_CH0L, c0[7:0]);
    wr(`DPSD_OFS_CH0H, c0[15:8]);
    wr(`DPSD_OFS_CH1L, c1[7:0]);
    wr(`DPSD_OFS_CH1H, c1[15:8]);
  endtask : setup

  // Control write with the count window opened at the same edge
  task automatic go(input logic [7:0] c, input int n);
    @(posedge clk_i);
    clr     <= 1'b1;
    addr_i  <= `DPSD_OFS_CTRL;
    wdata_i <= c;
    we_i    <= 1'b1;
    @(posedge clk_i);
    clr     <= 1'b0;
    we_i    <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : go

  task automatic window(input int n);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : window

  task automatic t_reset;
    check("oe_rst", {14'h0, out1_oe_o, out0_oe_o}, 16'h0000);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a));
      check("rd_rst", {8'h00, d}, 16'h0000);
    end
  endtask : t_reset

  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      wr(`DPSD_OFS_CTRL, {1'b0, 3'(m), 4'h3});
      #1;
      check("oe0", {15'h0, out0_oe_o}, 16'(m > 1 && m < 7));
      check("oe1", {15'h0, out1_oe_o}, 16'(m > 0 && m < 7));
    end
    wr(`DPSD_OFS_CTRL, 8'hb3);
    #1;
    check("single_output_only", {14'h0, out1_oe_o, out0_oe_o}, 16'h0002);
    check("pin_free", {15'h0, pin[0]}, 16'h0001);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`DPSD_OFS_CTRL, 8'h55);
    ce_i <= 1'b1;
    wr(3'h7, 8'hff);
    rd(3'h7);
    check("unmapped", {8'h00, d}, 16'h0000);
    rd(`DPSD_OFS_CTRL);
    check("ctrl_rd", {8'h00, d}, 16'h00b3);
  endtask : t_modes

  task automatic t_var;
    logic [7:0] c [4] = '{8'h13, 8'h11, 8'h12, 8'h10};
    int         n [4] = '{100, 300, 320, 300};
    int         e [4] = '{30, 90, 96, 90};
    setup(16'h0003, 16'h000a);
    foreach (c[i])
    begin
      go(c[i], 160);
      window(n[i]);
      check("var_out1", 16'(high1), 16'(e[i]));
      check("var_out0", 16'(high0), 16'h0000);
    end
    go(8'h13, 20);
    wr(`DPSD_OFS_CH0L, 8'h07);
    rd(`DPSD_OFS_CH0L);
    check("hidden", {8'h00, d}, 16'h0003);
    wr(`DPSD_OFS_CH0H, 8'h00);
    rd(`DPSD_OFS_CH0L);
    check("commit", {8'h00, d}, 16'h0007);
    repeat (12) @(posedge clk_i);
    window(100);
    check("var_new", 16'(high1), 16'd70);
  endtask : t_var

  task automatic t_twin16;
    logic [7:0] c [4] = '{8'h33, 8'h37, 8'h3b, 8'h3f};
    setup(16'h0002, 16'h0001);
    foreach (c[i])
    begin
      go(c[i], 300);
      check("tw_out0", 16'(high0), 16'(2 << (2 * i)));
      check("tw_out1", 16'(high1), 16'(1 << (2 * i)));
    end
    go(8'h33, 10);
    window(65536);
    check("tw_wrap0", 16'(high0), 16'h0002);
    check("tw_wrap1", 16'(high1), 16'h0001);
    go(8'h30, 100);
    rd(`DPSD_OFS_CNTL);
    check("cnt_run", 16'(d != 8'h00), 16'h0001);
    wr(`DPSD_OFS_CTRL, 8'h30);
    rd(`DPSD_OFS_CNTL);
    check("cnt_clr", {8'h00, d}, 16'h0000);
  endtask : t_twin16

  task automatic t_pattern;
    logic [15:0] c0 [4] = '{16'h0c05, 16'h0403, 16'h4000, 16'h4000};
    logic [15:0] c1 [4] = '{16'h0414, 16'h100a, 16'h8000, 16'h8000};
    logic [7:0]  c  [4] = '{8'h23, 8'h53, 8'h43, 8'h67};
    int          n  [4] = '{200, 80, 64, 256};
    int          e0 [4] = '{50, 24, 16, 32};
    int          e1 [4] = '{80, 20, 32, 64};
    int          r0 [4] = '{5, 3, 1, 2};
    foreach (c[i])
    begin
      setup(c0[i], c1[i]);
      go(c[i], 40);
      window(n[i]);
      check("pat_out0", 16'(high0), 16'(e0[i]));
      check("pat_out1", 16'(high1), 16'(e1[i]));
      check("pat_run0", 16'(run0), 16'(r0[i]));
    end
  endtask : t_pattern

  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    rst_i      = 1'b1;
    ce_i       = 1'b1;
    we_i       = 1'b0;
    re_i       = 1'b0;
    addr_i     = 3'h0;
    wdata_i    = 8'h00;
    clr        = 1'b0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_var();
    t_twin16();
    t_pattern();
    end_of_test();
  end

  // Whole run is about 69600 clocks; cut off well after that
  initial
  begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
endmodule : dpsd_top_test
